/* logic/tsca_pkg.sv */
// shared constants and checksum function for the temperature sensor link
package tsca_pkg;
  localparam int CLK_MHZ = 50;
  // conversion timing in microseconds and derived pclk counts
  localparam int CONV_US      = 5500;
  localparam int CONV_CYC_DEF = CONV_US * CLK_MHZ;
  localparam int PER_US       = 6250;
  localparam int PER_CYC_DEF  = PER_US * CLK_MHZ;
  // serial link timing
  localparam int LEAD_NS  = 100;
  localparam int LEAD_CYC = (LEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_NS   = 700;
  localparam int GAP_CYC  = (GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int SCLK_HALF = 4;
  // device sub-addresses
  localparam logic [7:0] A_RESULT = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h02;
  localparam logic [7:0] A_CONFIG = 8'h03;
  localparam logic [7:0] A_MASK   = 8'h04;
  localparam logic [7:0] A_TLOW   = 8'h05;
  localparam logic [7:0] A_THIGH  = 8'h06;
  localparam logic [7:0] A_SLEW   = 8'h07;
  // status bits
  localparam int ST_HIGH = 0;
  localparam int ST_LOW  = 1;
  localparam int ST_SLEW = 2;
  localparam int ST_DRDY = 3;
  localparam int ST_CRC  = 4;
  // config bits
  localparam int CF_MODE    = 0;
  localparam int CF_ONESHOT = 1;
  localparam int CF_COMP    = 2;
  localparam int CF_DRDY_EN = 3;
  localparam int CF_LIM_EN  = 4;
  localparam int CF_PER     = 5;
  // reset values
  localparam logic [15:0] CONFIG_RST = 16'h0010;
  localparam logic [15:0] MASK_RST   = 16'h0007;
  localparam logic [15:0] TLOW_RST   = 16'hec00;
  localparam logic [15:0] THIGH_RST  = 16'h3e80;
  localparam logic [15:0] SLEW_RST   = 16'h0100;
  // command word fields
  localparam int CMD_CRC = 14;
  localparam int CMD_LEN = 10;
  localparam int CMD_INC = 9;
  localparam int CMD_RD  = 8;
  localparam logic [3:0] LEN_MAX = 4'ha;
  localparam int WBUF_N = 10;
  // checksum
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  // host apb map
  localparam logic [11:0] H_CMD   = 12'h000;
  localparam logic [11:0] H_WDATA = 12'h004;
  localparam logic [11:0] H_RDATA = 12'h008;
  localparam logic [11:0] H_STAT  = 12'h00c;
  localparam int HC_GO    = 31;
  localparam int HC_CRC   = 9;
  localparam int HS_BUSY  = 0;
  localparam int HS_CRCE  = 1;
  localparam int HS_ALERT = 2;
  localparam int HS_REFUS = 3;

  function automatic logic [15:0] crc_word(input logic [15:0] c,
                                           input logic [15:0] w);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[15] ^ w[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction
endpackage

/* logic/tsca_if.sv */
// three-wire serial link between host controller and sensor
`timescale 1ns/1ns
interface tsca_if;
  logic sclk;
  logic cs_n;
  logic h_sio_o;
  logic h_sio_oe;
  logic d_sio_o;
  logic d_sio_oe;
  logic alert;
  logic sio;
  // pulled high when nobody drives
  assign sio = h_sio_oe ? h_sio_o : (d_sio_oe ? d_sio_o : 1'b1);
  modport dev (input sclk, cs_n, sio, output d_sio_o, d_sio_oe, alert);
  modport host (output sclk, cs_n, h_sio_o, h_sio_oe, input sio, alert);
endinterface

/* logic/tsca_dev.sv */
// sensor end: conversion sequencer, alert logic and serial register port
`timescale 1ns/1ns
//Contract
// - compare result with low and high limits
// - alert active when result outside limits
// - slew check only in continuous mode
// - rise over threshold sets slew status
// - falling temperature never reports slew
// - checksum bit plus valid length enables checksum
// - checksum-protected read appends 16-bit checksum
// - bad write checksum drops data, sets flag
// - host avoids checksum-protected config writes
// - continuous mode updates result at conversion end
// - done flag set; cleared reading status/result
// - done-to-pin select shows done on alert
// - fixed conversion then standby, period field
// - standby disables measurement, serial stays alive
// - mode bit aborts conversion into shutdown
// - mode switches keep pending alerts
// - no new slew alert in shutdown
// - trigger starts fresh conversion immediately
// - single conversion ends: done, shutdown, bits
// - retrigger restarts conversion, no update
// - interrupt style: alert until status read
// - comparator style: masked status, mask lags
// - ignore checksum for length zero or above ten
module tsca_dev #(
  parameter int CONV_CYC = tsca_pkg::CONV_CYC_DEF,
  parameter int PER_CYC  = tsca_pkg::PER_CYC_DEF
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  tsca_if.dev               bus,
  input  wire logic [15:0]  temp_in,
  output logic              meas_en
);
  import tsca_pkg::*;

  typedef enum logic [2:0] {
    C_OFF  = 3'b001,
    C_CONV = 3'b010,
    C_STBY = 3'b100
  } tsca_cst_t;

  logic [1:0]  sclk_s;
  logic        sclk_d;
  logic [1:0]  cs_s;
  logic [1:0]  sio_s;
  logic [3:0]  bitc_q;
  logic [3:0]  wcnt_q;
  logic [15:0] sh_q;
  logic [15:0] cmd_q;
  logic [7:0]  addr_q;
  logic [15:0] out_q;
  logic [15:0] nx_q;
  logic [15:0] crc_q;
  logic        oe_q;
  logic [15:0] wbuf [WBUF_N];
  logic [7:0]  wba [WBUF_N];
  logic [3:0]  cm_n_q;
  logic [3:0]  cm_i_q;
  logic [15:0] cfg_q;
  logic [15:0] mask_q;
  logic [15:0] meff_q;
  logic [15:0] tlow_q;
  logic [15:0] thigh_q;
  logic [15:0] slew_q;
  logic [15:0] result_q;
  logic [15:0] prev_q;
  logic        prev_v_q;
  logic [4:0]  flags_q;
  logic        alert_q;
  logic        meas_q;
  tsca_cst_t   st_q;
  logic [31:0] cnt_q;

  wire        sel    = ~cs_s[1];
  wire        rise   = sel & sclk_s[1] & ~sclk_d;
  wire        fall   = sel & ~sclk_s[1] & sclk_d;
  wire        wend   = rise & (bitc_q == 4'hf);
  wire [15:0] wnew   = {sh_q[14:0], sio_s[1]};
  wire        first  = (wcnt_q == 4'h0);
  wire [15:0] cmdv   = first ? wnew : cmd_q;
  wire [3:0]  len    = cmdv[CMD_LEN +: 4];
  // length zero or above ten leaves the transfer unprotected
  // length range check
  wire        crc_on = cmdv[CMD_CRC] & (len != 4'h0) & (len <= LEN_MAX);
  wire        rd     = cmdv[CMD_RD];
  wire [7:0]  addr_n = first ? wnew[7:0] :
                       (cmd_q[CMD_INC] ? addr_q + 8'h01 : addr_q);
  wire [3:0]  wi     = wcnt_q + 4'h1;
  wire        crcw_n = crc_on & (wi == len + 4'h1);
  wire        crcw   = crc_on & (wcnt_q == len + 4'h1);
  wire        past   = crc_on & (wcnt_q > len + 4'h1);
  wire [15:0] crcb   = first ? crc_word(CRC_INIT, wnew) : crc_q;
  wire        rdload = wend & rd & ~crcw_n & ~(crc_on & (wi > len + 4'h1));
  wire        rd_st  = rdload & (addr_n == A_STATUS);
  wire        rd_res = rdload & (addr_n == A_RESULT);
  wire        wr_now = wend & ~first & ~rd & ~crc_on;
  wire        wr_buf = wend & ~first & ~rd & crc_on & ~crcw & ~past;
  wire        crc_ok = wend & ~first & ~rd & crcw & (wnew == crc_q);
  wire        crc_bad = wend & ~first & ~rd & crcw & (wnew != crc_q);
  wire        commit = (cm_i_q != cm_n_q);
  wire        wr_en  = wr_now | commit;
  wire [7:0]  wr_a   = commit ? wba[cm_i_q] : addr_q;
  wire [15:0] wr_d   = commit ? wbuf[cm_i_q] : wnew;
  wire        wr_cfg = wr_en & (wr_a == A_CONFIG);
  wire        cont   = ~cfg_q[CF_MODE] & ~cfg_q[CF_ONESHOT];
  wire [31:0] per_end = 32'(PER_CYC) * {29'h0, cfg_q[CF_PER +: 3]}
                        + 32'(PER_CYC) - 32'h1;
  wire        done   = (st_q == C_CONV) & (cnt_q == 32'(CONV_CYC - 1));
  wire [16:0] rise_v = {temp_in[15], temp_in} - {prev_q[15], prev_q};
  wire        hi_hit = cfg_q[CF_LIM_EN] &
                       ($signed(temp_in) > $signed(thigh_q));
  wire        lo_hit = cfg_q[CF_LIM_EN] &
                       ($signed(temp_in) < $signed(tlow_q));
  wire        sl_hit = cont & prev_v_q & ~rise_v[16] &
                       (rise_v[15:0] > slew_q);
  wire        comp   = cfg_q[CF_COMP];
  wire [15:0] rd_data = reg_rd(addr_n);

  function automatic logic [15:0] reg_rd(input logic [7:0] a);
    case (a)
      A_RESULT: reg_rd = result_q;
      A_STATUS: reg_rd = {11'h0, flags_q};
      A_CONFIG: reg_rd = cfg_q;
      A_MASK:   reg_rd = mask_q;
      A_TLOW:   reg_rd = tlow_q;
      A_THIGH:  reg_rd = thigh_q;
      A_SLEW:   reg_rd = slew_q;
      default:  reg_rd = 16'h0000;
    endcase
  endfunction

  assign bus.d_sio_o  = out_q[15];
  assign bus.d_sio_oe = oe_q;
  assign bus.alert    = alert_q;
  assign meas_en      = meas_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_s <= 2'b00;
      sclk_d <= 1'b0;
      cs_s   <= 2'b11;
      sio_s  <= 2'b11;
    end else begin
      sclk_s <= {sclk_s[0], bus.sclk};
      sclk_d <= sclk_s[1];
      cs_s   <= {cs_s[0], bus.cs_n};
      sio_s  <= {sio_s[0], bus.sio};
    end
  end

  // serial word engine; stays live in every conversion state
  // serial port independent of standby
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bitc_q <= 4'h0;
      wcnt_q <= 4'h0;
      sh_q   <= 16'h0000;
      cmd_q  <= 16'h0000;
      addr_q <= 8'h00;
      out_q  <= 16'h0000;
      nx_q   <= 16'h0000;
      crc_q  <= CRC_INIT;
      oe_q   <= 1'b0;
      cm_n_q <= 4'h0;
      cm_i_q <= 4'h0;
    end else if (!sel) begin
      bitc_q <= 4'h0;
      wcnt_q <= 4'h0;
      oe_q   <= 1'b0;
      cm_i_q <= commit ? cm_i_q + 4'h1 : cm_i_q;
    end else begin
      cm_i_q <= commit ? cm_i_q + 4'h1 : cm_i_q;
      if (rise) begin
        sh_q   <= wnew;
        bitc_q <= bitc_q + 4'h1;
      end
      // output only moves on a falling edge, next word waits in nx_q
      if (fall && rd && !first) begin
        oe_q  <= 1'b1;
        out_q <= (bitc_q == 4'h0) ? nx_q : {out_q[14:0], 1'b0};
      end
      if (wend) begin
        wcnt_q <= (wcnt_q == 4'hf) ? wcnt_q : wi;
        addr_q <= addr_n;
        if (first) begin
          cmd_q <= wnew;
          crc_q <= crcb;
        end
        if (rd && crcw_n) begin
          // checksum word follows the data block
          nx_q <= crc_q;
        end else if (rdload) begin
          nx_q  <= rd_data;
          crc_q <= crc_word(crcb, rd_data);
        end
        if (wr_buf) begin
          crc_q <= crc_word(crc_q, wnew);
        end
        if (crc_ok) begin
          // commit buffered words only on a match
          cm_n_q <= len;
          cm_i_q <= 4'h0;
        end
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (wr_buf) begin
      wbuf[wcnt_q - 4'h1] <= wnew;
      wba[wcnt_q - 4'h1]  <= addr_q;
    end
  end

  // conversion timebase on pclk, never on the serial clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q     <= C_CONV;
      cnt_q    <= 32'h0;
      meas_q   <= 1'b0;
      cfg_q    <= CONFIG_RST;
      mask_q   <= MASK_RST;
      tlow_q   <= TLOW_RST;
      thigh_q  <= THIGH_RST;
      slew_q   <= SLEW_RST;
      result_q <= 16'h0000;
      prev_q   <= 16'h0000;
      prev_v_q <= 1'b0;
    end else begin
      meas_q <= (st_q == C_CONV) & ~done;
      cnt_q  <= cnt_q + 32'h1;
      if (wr_en) begin
        case (wr_a)
          A_MASK:  mask_q  <= wr_d;
          A_TLOW:  tlow_q  <= wr_d;
          A_THIGH: thigh_q <= wr_d;
          A_SLEW:  slew_q  <= wr_d;
          default: ;
        endcase
      end
      if (wr_cfg) begin
        cfg_q <= wr_d;
        if (wr_d[CF_ONESHOT]) begin
          st_q  <= C_CONV;
          cnt_q <= 32'h0;
        end else if (wr_d[CF_MODE]) begin
          st_q     <= C_OFF;
          prev_v_q <= 1'b0;
        end else if (st_q == C_OFF) begin
          st_q  <= C_CONV;
          cnt_q <= 32'h0;
        end
      end else begin
        case (st_q)
          C_OFF: cnt_q <= 32'h0;
          C_CONV: begin
            if (done) begin
              result_q <= temp_in;
              prev_q   <= temp_in;
              prev_v_q <= cont;
              if (cfg_q[CF_ONESHOT]) begin
                cfg_q[CF_MODE]    <= 1'b1;
                cfg_q[CF_ONESHOT] <= 1'b0;
                st_q              <= C_OFF;
              end else begin
                st_q <= C_STBY;
              end
            end
          end
          C_STBY: begin
            if (cnt_q >= per_end) begin
              st_q  <= C_CONV;
              cnt_q <= 32'h0;
            end
          end
          default: st_q <= C_OFF;
        endcase
      end
    end
  end

  // status flags: a hardware set wins over a read clear
  // mode changes never touch the flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= 5'h00;
      meff_q  <= MASK_RST;
      alert_q <= 1'b0;
    end else begin
      // interrupt bits clear on read, compare bits track
      flags_q[ST_HIGH] <= (done & hi_hit) | (flags_q[ST_HIGH] &
                          ~(comp ? done : rd_st));
      flags_q[ST_LOW]  <= (done & lo_hit) | (flags_q[ST_LOW] &
                          ~(comp ? done : rd_st));
      // comparator slew bit clears only at a continuous conversion end, so it holds in shutdown
      flags_q[ST_SLEW] <= (done & sl_hit) | (flags_q[ST_SLEW] &
                          ~(comp ? (done & cont) : rd_st));
      flags_q[ST_DRDY] <= done | (flags_q[ST_DRDY] & ~(rd_st | rd_res));
      flags_q[ST_CRC]  <= crc_bad | (flags_q[ST_CRC] & ~rd_st);
      // mask takes effect at conversion end or read
      if (done || rd_st || rd_res) begin
        meff_q <= mask_q;
      end
      alert_q <= (|(flags_q[2:0] & meff_q[2:0])) |
                 (cfg_q[CF_DRDY_EN] & flags_q[ST_DRDY]);
    end
  end
endmodule

/* logic/tsca_host.sv */
// host end: apb command registers driving the three-wire link
`timescale 1ns/1ns
module tsca_host (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [11:0]  paddr,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  tsca_if.host              bus
);
  import tsca_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_LEAD = 4'b0010,
    H_BIT  = 4'b0100,
    H_GAP  = 4'b1000
  } tsca_hst_t;

  tsca_hst_t   st_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [9:0]  cmd_q;
  logic [15:0] wdat_q;
  logic [15:0] rdat_q;
  logic        crce_q;
  logic        refus_q;
  logic [1:0]  alert_s;
  logic [1:0]  sio_s;
  logic [47:0] tx_q;
  logic [31:0] rx_q;
  logic [5:0]  bi_q;
  logic [7:0]  cnt_q;
  logic        sclk_q;
  logic        cs_n_q;
  logic        oe_q;

  wire        acc    = psel & penable & pready_q;
  wire        map_ok = (paddr == H_CMD) | (paddr == H_WDATA) |
                       (paddr == H_RDATA) | (paddr == H_STAT);
  wire        go_w   = acc & pwrite & (paddr == H_CMD) & pwdata[HC_GO] &
                       (st_q == H_IDLE);
  wire        crc_r  = pwdata[HC_CRC];
  wire        refuse = go_w & crc_r & ~pwdata[CMD_RD] &
                       (pwdata[7:0] == A_CONFIG);
  wire [15:0] cmdw   = {1'b0, crc_r, crc_r ? 4'h1 : 4'h0, 1'b0,
                        pwdata[CMD_RD], pwdata[7:0]};
  wire [15:0] crcw   = crc_word(crc_word(CRC_INIT, cmdw), wdat_q);
  wire [5:0]  last   = cmd_q[HC_CRC] ? 6'h2f : 6'h1f;
  wire [15:0] rword  = cmd_q[HC_CRC] ? rx_q[31:16] : rx_q[15:0];
  // command word rebuilt from cmd_q: tx_q is shifted out by frame end
  wire [15:0] cmdr   = {1'b0, cmd_q[HC_CRC], 3'h0, cmd_q[HC_CRC], 1'b0,
                        cmd_q[8:0]};
  wire [15:0] rcrc   = crc_word(crc_word(CRC_INIT, cmdr), rword);
  wire        ph_end = (cnt_q == 8'(2 * SCLK_HALF - 1));
  wire [31:0] rd_mux = (paddr == H_CMD)   ? {22'h0, cmd_q} :
                       (paddr == H_WDATA) ? {16'h0, wdat_q} :
                       (paddr == H_RDATA) ? {16'h0, rdat_q} :
                       (paddr == H_STAT)  ? {28'h0, refus_q, alert_s[1],
                                             crce_q, st_q != H_IDLE} :
                       32'h0;

  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign bus.sclk     = sclk_q;
  assign bus.cs_n     = cs_n_q;
  assign bus.h_sio_o  = tx_q[47];
  assign bus.h_sio_oe = oe_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
      alert_s   <= 2'b00;
      sio_s     <= 2'b11;
    end else begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~map_ok;
      prdata_q  <= (psel & penable & ~pready_q & ~pwrite) ? rd_mux : 32'h0;
      alert_s   <= {alert_s[0], bus.alert};
      sio_s     <= {sio_s[0], bus.sio};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= H_IDLE;
      cmd_q   <= 10'h000;
      wdat_q  <= 16'h0000;
      rdat_q  <= 16'h0000;
      crce_q  <= 1'b0;
      refus_q <= 1'b0;
      tx_q    <= 48'h0;
      rx_q    <= 32'h0;
      bi_q    <= 6'h00;
      cnt_q   <= 8'h00;
      sclk_q  <= 1'b0;
      cs_n_q  <= 1'b1;
      oe_q    <= 1'b0;
    end else begin
      if (acc && pwrite && paddr == H_WDATA && st_q == H_IDLE) begin
        wdat_q <= pwdata[15:0];
      end
      cnt_q <= cnt_q + 8'h01;
      case (st_q)
        H_IDLE: begin
          if (go_w) begin
            refus_q <= refuse;
            crce_q  <= 1'b0;
            if (!refuse) begin
              cmd_q  <= {crc_r, pwdata[CMD_RD], pwdata[7:0]};
              tx_q   <= {cmdw, wdat_q, crcw};
              cs_n_q <= 1'b0;
              oe_q   <= 1'b1;
              cnt_q  <= 8'h00;
              bi_q   <= 6'h00;
              st_q   <= H_LEAD;
            end
          end
        end
        H_LEAD: begin
          if (cnt_q == 8'(LEAD_CYC - 1)) begin
            cnt_q <= 8'h00;
            st_q  <= H_BIT;
          end
        end
        H_BIT: begin
          sclk_q <= (cnt_q >= 8'(SCLK_HALF - 1)) & ~ph_end;
          if (ph_end) begin
            rx_q  <= {rx_q[30:0], sio_s[1]};
            cnt_q <= 8'h00;
            if (bi_q == last) begin
              oe_q   <= 1'b0;
              cs_n_q <= 1'b1;
              st_q   <= H_GAP;
            end else begin
              bi_q <= bi_q + 6'h01;
              tx_q <= {tx_q[46:0], 1'b0};
              oe_q <= ~cmd_q[CMD_RD] | (bi_q < 6'h0f);
            end
          end
        end
        H_GAP: begin
          if (cnt_q == 8'(GAP_CYC - 1)) begin
            st_q <= H_IDLE;
            if (cmd_q[CMD_RD]) begin
              rdat_q <= rword;
              crce_q <= cmd_q[HC_CRC] & (rx_q[15:0] != rcrc);
            end
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end
endmodule

/* tb/tsca_assertions.sv */
// wire-level checks on the serial link between the two ends
`timescale 1ns/1ns
module tsca_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic h_sio_o,
  input wire logic h_sio_oe,
  input wire logic d_sio_o,
  input wire logic d_sio_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_one_driver: assert property (!(h_sio_oe && d_sio_oe))
    else $error("both ends drive the data line");
  a_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock active outside a frame");
  a_lead_time: assert property ($fell(cs_n) |-> !sclk [*5])
    else $error("first clock edge too soon after select");
  a_high_phase: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("serial clock high phase is not four cycles");
  a_low_phase: assert property ($fell(sclk) |-> !sclk [*4])
    else $error("serial clock low phase too short");
  a_frame_gap: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("frames too close together");
  a_host_hold: assert property (
    sclk && $past(sclk) && h_sio_oe |-> $stable(h_sio_o))
    else $error("host data moved while clock high");
  a_dev_hold: assert property (
    sclk && $past(sclk) && d_sio_oe |-> $stable(d_sio_o))
    else $error("sensor data moved while clock high");
  a_dev_release: assert property (
    cs_n && $past(cs_n, 8) |-> !d_sio_oe)
    else $error("sensor drives data line while deselected");
endmodule

/* tb/tb.sv */
// self-checking bench: apb host end and sensor end joined by the link
`timescale 1ns/1ns
module tb;
  import tsca_pkg::*;
  logic        pclk;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] temp_in;
  logic        meas_en;
  logic [31:0] q;
  logic [31:0] st;
  logic        err;
  int          failures;
  int          checked;
  tsca_if bus ();
  tsca_dev #(.CONV_CYC(200), .PER_CYC(300)) i_tsca_dev (
    .pclk(pclk), .presetn(presetn), .bus(bus),
    .temp_in(temp_in), .meas_en(meas_en));
  tsca_host i_tsca_host (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus));
  tsca_assertions i_tsca_assertions (
    .pclk(pclk), .presetn(presetn), .sclk(bus.sclk), .cs_n(bus.cs_n),
    .h_sio_o(bus.h_sio_o), .h_sio_oe(bus.h_sio_oe),
    .d_sio_o(bus.d_sio_o), .d_sio_oe(bus.d_sio_oe));

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one link frame: status ends in st, read data in q
  task automatic dev(input logic [7:0] s, input logic r, input logic c,
                     input logic [15:0] d);
    int n;
    n = 0;
    apb(H_WDATA, 1'b1, {16'h0, d});
    apb(H_CMD, 1'b1, {1'b1, 21'h0, c, r, s});
    do begin
      apb(H_STAT, 1'b0, 32'h0);
      n++;
    end while (q[HS_BUSY] !== 1'b0 && n < 400);
    check({31'h0, q[HS_BUSY]}, 32'h0);
    st = q;
    apb(H_RDATA, 1'b0, 32'h0);
  endtask

  task automatic rd(input logic [7:0] s);
    dev(s, 1'b1, 1'b0, 16'h0);
  endtask

  task automatic wr(input logic [7:0] s, input logic [15:0] d);
    dev(s, 1'b0, 1'b0, d);
  endtask

  task automatic temp(input logic [15:0] t);
    temp_in <= t;
    repeat (700) @(posedge pclk);
  endtask

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial begin
    #1500000;
    $display("mismatch at %0t: watchdog expired", $time);
    failures++;
    test_done();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    temp_in = 16'h0c80;
    failures = 0;
    checked = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_CONFIG);
    check(q, {16'h0, CONFIG_RST});
    rd(A_TLOW);
    check(q, {16'h0, TLOW_RST});
    apb(12'h010, 1'b0, 32'h0);
    check({31'h0, err}, 32'h1);
    temp(16'h0c80);
    rd(A_STATUS);
    check(q, 32'h8);
    rd(A_RESULT);
    check(q, 32'h0c80);
    $display("continuous test done");
    temp(16'h4000);
    check({31'h0, bus.alert}, 32'h1);
    temp(16'h0c80);
    rd(A_STATUS);
    check(q, 32'hd);
    repeat (20) @(posedge pclk);
    check({31'h0, bus.alert}, 32'h0);
    temp(16'h0a00);
    rd(A_STATUS);
    check(q, 32'h8);
    temp(16'he000);
    rd(A_STATUS);
    check(q, 32'ha);
    temp(16'h0d80);
    rd(A_STATUS);
    temp(16'h0e80);
    rd(A_STATUS);
    check(q, 32'h8);
    temp(16'h0f84);
    rd(A_STATUS);
    check(q, 32'hc);
    $display("limit and slew test done");
    wr(A_CONFIG, 16'h0014);
    temp(16'h4000);
    rd(A_STATUS);
    check({31'h0, bus.alert}, 32'h1);
    wr(A_MASK, 16'h0000);
    repeat (300) @(posedge pclk);
    check({31'h0, bus.alert}, 32'h0);
    wr(A_MASK, 16'h0007);
    temp(16'h0c80);
    check({31'h0, bus.alert}, 32'h0);
    $display("comparator test done");
    wr(A_CONFIG, 16'h0011);
    rd(A_STATUS);
    check(q, 32'h8);
    check({31'h0, meas_en}, 32'h0);
    temp(16'h1000);
    rd(A_RESULT);
    check(q, 32'h0c80);
    wr(A_CONFIG, 16'h0013);
    check({31'h0, meas_en}, 32'h1);
    repeat (300) @(posedge pclk);
    rd(A_CONFIG);
    check(q, 32'h0011);
    rd(A_STATUS);
    check(q, 32'h8);
    rd(A_RESULT);
    check(q, 32'h1000);
    rd(A_STATUS);
    check(q, 32'h0);
    $display("shutdown test done");
    dev(A_TLOW, 1'b1, 1'b1, 16'h0);
    check(q, {16'h0, TLOW_RST});
    check({31'h0, st[HS_CRCE]}, 32'h0);
    dev(A_SLEW, 1'b0, 1'b1, 16'h0200);
    rd(A_SLEW);
    check(q, 32'h0200);
    dev(A_CONFIG, 1'b0, 1'b1, 16'h0000);
    check({31'h0, st[HS_REFUS]}, 32'h1);
    rd(A_CONFIG);
    check(q, 32'h0011);
    $display("checksum test done");
    wr(A_CONFIG, 16'h001b);
    repeat (300) @(posedge pclk);
    check({31'h0, bus.alert}, 32'h1);
    rd(A_CONFIG);
    check(q, 32'h0019);
    check({31'h0, st[HS_ALERT]}, 32'h1);
    rd(A_STATUS);
    check(q, 32'h8);
    check({31'h0, bus.alert}, 32'h0);
    $display("done pin test done");
    test_done();
  end
endmodule
